//--- design/reset_source_defines.vh
/*
 * Constants for the reset source controller: oscillator modes, cause codes,
 * reset values and filter timing.
 * Assumes a 100 MHz core clock; included by the design files by bare name.
 */
`ifndef RESET_SOURCE_DEFINES_VH
`define RESET_SOURCE_DEFINES_VH

// ****************************************************************
// Clock and filter timing
// ****************************************************************
`define CLK_PERIOD_NS      10
`define PIN_MIN_WIDTH_NS   2000
`define PIN_MIN_CYCLES     ((`PIN_MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_W             8

// ****************************************************************
// Cause codes, one bit per cause
// ****************************************************************
`define CAUSE_W            6
`define CAUSE_POWER_ON     6'h01
`define CAUSE_PIN_RUN      6'h02
`define CAUSE_PIN_SLEEP    6'h04
`define CAUSE_WDT_RESET    6'h08
`define CAUSE_WDT_WAKE     6'h10
`define CAUSE_BROWN_OUT    6'h20

// ****************************************************************
// Reset values and oscillator modes
// ****************************************************************
`define PC_W               13
`define PC_RESET_VALUE     13'h0000
`define DATA_RESET_VALUE   8'h00
`define OSC_LP             2'h0
`define OSC_XT             2'h1
`define OSC_HS             2'h2
`define OSC_RC             2'h3

`endif

//--- design/reset_pin_filter.v
/*
 * Glitch filter for the active-low external reset pin.
 * Assumes the pin is already synchronous to clk_i; outputs a registered,
 * filtered low-active level that only asserts after the minimum width.
 */
`timescale 1ns/1ps
`include "reset_source_defines.vh"

module reset_pin_filter (
    input  wire       clk_i,        // Core clock.
    input  wire       rst_n_i,      // Asynchronous reset, active low.
    input  wire       pin_n_i,      // Synchronised reset pin level.
    output reg        filtered_n_o  // Filtered pin, active low.
);

    // ****************************************************************
    // Low-width counter
    // ****************************************************************
    reg [`FILT_W-1:0] low_count;    // Cycles the pin has been low.

    // Count while low; any high sample restarts the count, so glitches vanish.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_count    <= {`FILT_W{1'b0}};
            filtered_n_o <= 1'b1;
        end else if (pin_n_i) begin
            low_count    <= {`FILT_W{1'b0}};
            filtered_n_o <= 1'b1;
        end else if (low_count >= `PIN_MIN_CYCLES - 1) begin
            filtered_n_o <= 1'b0;
        end else begin
            low_count <= low_count + 1'b1;
        end
    end

endmodule

//--- design/reset_source_controller.v
/*
 * Reset source controller: classifies reset causes, drives the register
 * reset and hold strobes, keeps timeout and power-down flags and the
 * power-on and brown-out status bits, and picks the restart address.
 * Assumes supply, brown-out, watchdog and sleep signals are synchronous
 * single-bit levels or pulses from the surrounding core logic.
 */
`timescale 1ns/1ps
`include "reset_source_defines.vh"

module reset_source_controller (
    input  wire              clk_i,              // Core clock, 100 MHz.
    input  wire              rst_n_i,            // Asynchronous reset, active low.
    input  wire              supply_rise_i,      // Supply-rise detect level.
    input  wire              brown_out_reset_i,  // Brown-out condition level.
    input  wire              watchdog_timer_i,   // Watchdog overflow pulse.
    input  wire              interrupt_wake_i,   // Interrupt wake pulse.
    input  wire              sleeping_i,         // Core is in sleep.
    input  wire              external_reset_n_i, // Reset pin level, active low.
    input  wire              brown_out_set_i,    // Software sets brown-out bit.
    input  wire [`PC_W-1:0]  pc_i,               // Current program counter.
    input  wire [1:0]        osc_mode_i,         // Oscillator mode select.
    input  wire              ext_clock_sel_i,    // External clock on input pin.
    output reg               core_reset_n_o,     // Internal core reset, active low.
    output reg               load_defaults_o,    // Load reset values pulse.
    output reg               hold_retained_o,    // Retained group untouched.
    output reg  [`CAUSE_W-1:0] cause_o,          // Last cause, one-hot.
    output reg               timeout_flag_o,     // Timeout flag.
    output reg               power_down_flag_o,  // Power-down flag.
    output reg               power_on_status_o,  // Power-on status bit.
    output reg               brown_out_status_o, // Brown-out status bit.
    output reg  [`PC_W-1:0]  next_pc_o,          // Restart address.
    output reg               pc_load_o,          // Restart address valid pulse.
    output reg               clock_from_pin_o,   // Use pin as core clock.
    output reg               reset_pin_oe_o,     // Pin drive enable, always off.
    output reg               reset_pin_o         // Pin drive value.
);

    // ****************************************************************
    // States, one-hot
    // ****************************************************************
    localparam [2:0] ST_RUN   = 3'b001; // Running or sleeping normally.
    localparam [2:0] ST_HOLD  = 3'b010; // A reset source is still active.
    localparam [2:0] ST_REL   = 3'b100; // Release edge, synchronous.

    reg [2:0]          state;        // Current state.
    reg [2:0]          next_state;   // Next state.
    reg                pin_meta;     // First stage of pin synchroniser.
    reg                pin_sync;     // Second stage of pin synchroniser.
    reg                supply_q;     // Supply level last cycle.
    reg                por_pending;  // Power-on pulse seen, reset not yet released.
    wire               pin_filt_n;   // Filtered pin, active low.
    wire               por_pulse;    // Rising supply edge.
    wire               pin_low;      // Valid pin reset present.
    reg [`CAUSE_W-1:0] next_cause;   // Winning cause this cycle.

    // Priority picker; used for both the cause latch and the reset entry test in ST_RUN.
    function [`CAUSE_W-1:0] pick_cause;
        input por;
        input bor;
        input pin;
        input slp;
        input wdt;
        begin
            if (por)
                pick_cause = `CAUSE_POWER_ON;
            else if (bor)
                pick_cause = `CAUSE_BROWN_OUT;
            else if (pin)
                pick_cause = slp ? `CAUSE_PIN_SLEEP : `CAUSE_PIN_RUN;
            else if (wdt)
                pick_cause = slp ? `CAUSE_WDT_WAKE : `CAUSE_WDT_RESET;
            else
                pick_cause = {`CAUSE_W{1'b0}};
        end
    endfunction

    // ****************************************************************
    // Pin synchroniser and filter
    // ****************************************************************
    // Two flops first; only the second stage feeds the filter.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= external_reset_n_i;
            pin_sync <= pin_meta;
        end
    end

    reset_pin_filter u_filter (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .pin_n_i      (pin_sync),
        .filtered_n_o (pin_filt_n)
    );

    assign pin_low   = ~pin_filt_n;
    assign por_pulse = supply_rise_i & ~supply_q;

    // Power-on pulse capture; set wins over the clear by the state machine.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            supply_q    <= 1'b0;
            por_pending <= 1'b0;
        end else begin
            supply_q <= supply_rise_i;
            if (por_pulse)
                por_pending <= 1'b1;
            else if (state == ST_REL)
                por_pending <= 1'b0;
        end
    end

    // ****************************************************************
    // Cause selection and state machine
    // ****************************************************************
    always @* begin
        next_cause = pick_cause(por_pending | por_pulse, brown_out_reset_i,
                                pin_low, sleeping_i, watchdog_timer_i);
        case (state)
            ST_RUN: begin
                // Interrupt wakes and watchdog wakes do not enter reset.
                if (next_cause != {`CAUSE_W{1'b0}} && next_cause != `CAUSE_WDT_WAKE)
                    next_state = ST_HOLD;
                else
                    next_state = ST_RUN;
            end
            ST_HOLD: begin
                // Stay while the pin or brown-out is still held.
                if (pin_low || brown_out_reset_i)
                    next_state = ST_HOLD;
                else
                    next_state = ST_REL;
            end
            ST_REL:  next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // ****************************************************************
    // Outputs, flags and status bits
    // ****************************************************************
    // Every output is registered; the pin drive is never enabled.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_reset_n_o     <= 1'b0;
            load_defaults_o    <= 1'b0;
            hold_retained_o    <= 1'b1;
            cause_o            <= {`CAUSE_W{1'b0}};
            timeout_flag_o     <= 1'b1;
            power_down_flag_o  <= 1'b1;
            power_on_status_o  <= 1'b0;
            brown_out_status_o <= 1'b0;
            next_pc_o          <= `PC_RESET_VALUE;
            pc_load_o          <= 1'b0;
            clock_from_pin_o   <= 1'b0;
            reset_pin_oe_o     <= 1'b0;
            reset_pin_o        <= 1'b0;
        end else begin
            reset_pin_oe_o   <= 1'b0;
            reset_pin_o      <= 1'b0;
            hold_retained_o  <= 1'b1;
            load_defaults_o  <= 1'b0;
            pc_load_o        <= 1'b0;
            // Crystal modes may run from a driven clock instead of a crystal.
            clock_from_pin_o <= (osc_mode_i != `OSC_RC) & ext_clock_sel_i;
            // Core reset released on a clock edge only after sources drop.
            core_reset_n_o   <= (next_state == ST_RUN);
            if (brown_out_set_i)
                brown_out_status_o <= 1'b1;
            if (state == ST_RUN && next_cause != {`CAUSE_W{1'b0}}) begin
                cause_o <= next_cause;
                case (next_cause)
                    `CAUSE_POWER_ON: begin
                        timeout_flag_o    <= 1'b1;
                        power_down_flag_o <= 1'b1;
                        power_on_status_o <= 1'b0;
                    end
                    `CAUSE_BROWN_OUT: begin
                        timeout_flag_o     <= 1'b1;
                        power_down_flag_o  <= 1'b1;
                        brown_out_status_o <= 1'b0;
                    end
                    `CAUSE_PIN_SLEEP: begin
                        timeout_flag_o    <= 1'b1;
                        power_down_flag_o <= 1'b0;
                    end
                    `CAUSE_WDT_RESET: begin
                        timeout_flag_o    <= 1'b0;
                        power_down_flag_o <= 1'b1;
                    end
                    `CAUSE_WDT_WAKE: begin
                        timeout_flag_o    <= 1'b0;
                        power_down_flag_o <= 1'b0;
                        next_pc_o         <= pc_i + 1'b1;
                        pc_load_o         <= 1'b1;
                    end
                    default: begin
                        // Pin reset while running leaves both flags unchanged.
                    end
                endcase
            end else if (state == ST_RUN && interrupt_wake_i && sleeping_i) begin
                timeout_flag_o    <= 1'b1;
                power_down_flag_o <= 1'b0;
                next_pc_o         <= pc_i + 1'b1;
                pc_load_o         <= 1'b1;
            end
            if (state == ST_REL) begin
                load_defaults_o <= 1'b1;
                next_pc_o       <= `PC_RESET_VALUE;
                pc_load_o       <= 1'b1;
            end
        end
    end

endmodule

//--- tb/ext_reset_source.sv
/* Board-level reset source model driving the active-low reset pin.
   Assumes a pull-up on the pin and a bench that starts pulses. */
`timescale 1ns/1ps

module ext_reset_source (
    input  wire        clk_i,        // Core clock, used for timing only.
    input  wire        start_i,      // Begin one low pulse.
    input  wire [15:0] low_cycles_i, // Length of the low pulse in cycles.
    output reg         pin_n_o       // Reset pin level.
);
    reg [15:0] left = 16'h0000;      // Cycles still to hold the pin low.

    initial begin
        pin_n_o = 1'b1;
    end

    // Moves on the rising edge by non-blocking assignment, so the device samples
    // the settled level there; the bench changes start_i on the falling edge.
    always @(posedge clk_i) begin
        if (start_i) begin
            left    <= low_cycles_i - 16'h0001;
            pin_n_o <= 1'b0;
        end else if (left != 16'h0000) begin
            left <= left - 16'h0001;
        end else begin
            pin_n_o <= 1'b1; // The pull-up wins once released.
        end
    end
endmodule

//--- tb/reset_source_assertions.sv
/* Port checker for the reset source controller.
   Assumes it is bound to the controller and sees its ports only. */
`timescale 1ns/1ps
`include "reset_source_defines.vh"

module reset_source_assertions (
    input wire                clk_i,
    input wire                rst_n_i,
    input wire                supply_rise_i,
    input wire                brown_out_reset_i,
    input wire                watchdog_timer_i,
    input wire                sleeping_i,
    input wire                external_reset_n_i,
    input wire [`PC_W-1:0]    pc_i,
    input wire                core_reset_n_o,
    input wire                load_defaults_o,
    input wire                hold_retained_o,
    input wire [`CAUSE_W-1:0] cause_o,
    input wire                timeout_flag_o,
    input wire                power_down_flag_o,
    input wire                power_on_status_o,
    input wire                brown_out_status_o,
    input wire [`PC_W-1:0]    next_pc_o,
    input wire                pc_load_o,
    input wire                reset_pin_oe_o
);
    // ****************************************************************
    // Relations between ports
    // ****************************************************************
    // Running with no pin or brown-out source pending.
    wire quiet = core_reset_n_o && external_reset_n_i && !brown_out_reset_i;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    pin_never_driven_a: assert property (!reset_pin_oe_o)
        else $error("reset pin drive enable raised");
    retained_kept_a: assert property (hold_retained_o)
        else $error("retained group hold dropped");
    wdt_reset_a: assert property (quiet && !$rose(supply_rise_i) && watchdog_timer_i
        && !sleeping_i |=> cause_o == `CAUSE_WDT_RESET && !timeout_flag_o
        && power_down_flag_o && !core_reset_n_o)
        else $error("watchdog reset flags wrong");
    wdt_wake_a: assert property (quiet && !$rose(supply_rise_i) && watchdog_timer_i
        && sleeping_i |=> cause_o == `CAUSE_WDT_WAKE && !timeout_flag_o && !power_down_flag_o
        && pc_load_o && !load_defaults_o && core_reset_n_o
        && next_pc_o == $past(pc_i) + 13'h0001)
        else $error("watchdog wake handled as reset");
    power_on_a: assert property ($rose(supply_rise_i) && core_reset_n_o |=>
        cause_o == `CAUSE_POWER_ON && timeout_flag_o && power_down_flag_o
        && !power_on_status_o && !core_reset_n_o)
        else $error("power-on event not recorded first");
    brown_out_a: assert property (brown_out_reset_i && core_reset_n_o
        && !$rose(supply_rise_i) |=> cause_o == `CAUSE_BROWN_OUT && timeout_flag_o
        && power_down_flag_o && !brown_out_status_o && !core_reset_n_o)
        else $error("brown-out event not recorded");
    release_load_a: assert property ($rose(core_reset_n_o) && $past(rst_n_i, 2) |->
        load_defaults_o && pc_load_o && next_pc_o == `PC_RESET_VALUE)
        else $error("release without default load");
    sync_release_a: assert property (load_defaults_o |->
        core_reset_n_o && $past(core_reset_n_o) == 1'b0)
        else $error("default load not at reset release");
endmodule

bind reset_source_controller reset_source_assertions CHK (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_rise_i(supply_rise_i),
    .brown_out_reset_i(brown_out_reset_i), .watchdog_timer_i(watchdog_timer_i),
    .sleeping_i(sleeping_i), .external_reset_n_i(external_reset_n_i), .pc_i(pc_i),
    .core_reset_n_o(core_reset_n_o), .load_defaults_o(load_defaults_o),
    .hold_retained_o(hold_retained_o), .cause_o(cause_o), .timeout_flag_o(timeout_flag_o),
    .power_down_flag_o(power_down_flag_o), .power_on_status_o(power_on_status_o),
    .brown_out_status_o(brown_out_status_o), .next_pc_o(next_pc_o),
    .pc_load_o(pc_load_o), .reset_pin_oe_o(reset_pin_oe_o));

//--- tb/testbench.sv
/* Self-checking bench for the reset source controller.
   Assumes the board reset model and the bound port checker. */
`timescale 1ns/1ps
`include "reset_source_defines.vh"

module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, supply_rise = 1'b0, brown_out = 1'b0;
    logic        watchdog = 1'b0, int_wake = 1'b0, sleeping = 1'b0, bo_set = 1'b0;
    logic        ext_sel = 1'b1, pin_go = 1'b0;
    logic [12:0] pc = 13'h0123;       // Program counter seen by the block.
    logic [1:0]  osc_mode = `OSC_LP;  // Oscillator mode select.
    logic [15:0] pin_len = 16'h0000;  // Requested pin pulse length.
    wire         pin_n, core_rst_n, load_def, hold_ret, to_f, pd_f, por_s, bor_s;
    wire         pc_load, clk_pin, pin_oe, pin_val;
    wire [5:0]   cause;
    wire [12:0]  next_pc;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;

    ext_reset_source PIN (.clk_i(clk), .start_i(pin_go), .low_cycles_i(pin_len),
        .pin_n_o(pin_n));

    reset_source_controller DUT (.clk_i(clk), .rst_n_i(rst_n), .supply_rise_i(supply_rise),
        .brown_out_reset_i(brown_out), .watchdog_timer_i(watchdog),
        .interrupt_wake_i(int_wake), .sleeping_i(sleeping), .external_reset_n_i(pin_n),
        .brown_out_set_i(bo_set), .pc_i(pc), .osc_mode_i(osc_mode),
        .ext_clock_sel_i(ext_sel), .core_reset_n_o(core_rst_n), .load_defaults_o(load_def),
        .hold_retained_o(hold_ret), .cause_o(cause), .timeout_flag_o(to_f),
        .power_down_flag_o(pd_f), .power_on_status_o(por_s), .brown_out_status_o(bor_s),
        .next_pc_o(next_pc), .pc_load_o(pc_load), .clock_from_pin_o(clk_pin),
        .reset_pin_oe_o(pin_oe), .reset_pin_o(pin_val));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A one-cycle watchdog overflow, asleep or running.
    task pulse_wd(input logic s);
        sleeping = s;
        watchdog = 1'b1;
        step(1);
        watchdog = 1'b0;
    endtask

    // A low pulse on the pin; the model takes the request at the next rising edge.
    task pin_pulse(input logic [15:0] n, input int wait_n);
        pin_len = n;
        pin_go = 1'b1;
        step(1);
        pin_go = 1'b0;
        step(wait_n);
    endtask

    // Bounded wait for the release; restart must be at address zero.
    task wait_load;
        int i;
        i = 0;
        while (load_def !== 1'b1 && i < 60) begin
            step(1);
            i++;
        end
        chk("restart", {2'h3, `PC_RESET_VALUE}, {pc_load, core_rst_n, next_pc});
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the tests need about 710 cycles.
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        step(12);
        rst_n = 1'b1;
        step(3);
        pulse_wd(1'b0);
        chk("cause", `CAUSE_WDT_RESET, cause);
        chk("flags", 3'h2, {to_f, pd_f, core_rst_n});
        wait_load;
        $display("watchdog reset test done");
        pulse_wd(1'b1);
        chk("wake", {3'h4, 13'h0124}, {core_rst_n, to_f, pd_f, next_pc});
        chk("wake cause", `CAUSE_WDT_WAKE, {load_def, cause});
        int_wake = 1'b1;
        step(1);
        int_wake = 1'b0;
        chk("int wake", {3'h6, 13'h0124}, {core_rst_n, to_f, pd_f, next_pc});
        $display("wake test done");
        pin_pulse(16'd250, 225);
        chk("pin sleep", {2'h2, `CAUSE_PIN_SLEEP}, {to_f, pd_f, cause});
        chk("pin drive", 3'h0, {pin_oe, pin_val, core_rst_n});
        chk("retained", 1'b1, hold_ret);
        sleeping = 1'b0;
        wait_load;
        pin_pulse(16'd195, 200);
        chk("short pin", {1'b1, `CAUSE_PIN_SLEEP}, {core_rst_n, cause});
        pin_pulse(16'd210, 208);
        chk("pin run", {2'h2, `CAUSE_PIN_RUN}, {to_f, pd_f, cause});
        wait_load;
        $display("pin test done");
        bo_set = 1'b1;
        step(1);
        bo_set = 1'b0;
        step(1);
        chk("bo set", 1'b1, bor_s);
        brown_out = 1'b1;
        step(3);
        chk("brown-out", {3'h6, `CAUSE_BROWN_OUT}, {to_f, pd_f, bor_s, cause});
        chk("bo held", 1'b0, core_rst_n);
        brown_out = 1'b0;
        wait_load;
        supply_rise = 1'b1;
        watchdog = 1'b1;
        step(1);
        watchdog = 1'b0;
        chk("power-on", {3'h6, `CAUSE_POWER_ON}, {to_f, pd_f, por_s, cause});
        chk("por reset", 1'b0, core_rst_n);
        wait_load;
        $display("brown-out and power-on test done");
        for (int m = 0; m < 5; m++) begin
            osc_mode = m[1:0];
            ext_sel = (m < 4);
            step(2);
            chk("clock pin", (m < 3), clk_pin);
        end
        $display("oscillator test done");
        report_and_stop;
    end
endmodule
